// ===== verilog/csdr_routing.sv
`timescale 1ns/100ps
module csdr_routing
  import csdr_pkg::*;
#(
  parameter int HPF_K = CSDR_HPF_K,
  parameter int CHAIN_LEN = CSDR_CHAIN_LEN
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic bit_clk,
  input wire logic frame_sync,
  input wire logic serial_in_primary,
  input wire logic serial_in_secondary,
  output logic serial_out_primary,
  output logic serial_out_secondary,
  input wire csdr_cfg_t serial_port_control,
  input wire logic highpass_enable,
  input wire logic conv_valid,
  input wire logic [CSDR_NUM_CH-1:0][CSDR_RAW_W-1:0] conv_raw,
  input wire logic overflow_clear,
  output logic input_overflow,
  input wire logic [CSDR_NUM_CH-1:0] mute,
  input wire logic [CSDR_NUM_CH-1:0][7:0] chan_att,
  input wire logic [7:0] master_att,
  output csdr_quad_t playback_channels,
  output logic playback_valid
);

  // Clock domain: converter side
  csdr_quad_t sat_w;
  csdr_quad_t hpf_w;
  logic [CSDR_NUM_CH-1:0] over_w;
  logic [CSDR_NUM_CH-1:0][HPF_K+23:0] dc_q;
  csdr_quad_t tx_hold_q;
  logic tx_req_q;
  logic tx_ack_s1_q;
  logic tx_ack_s2_q;
  logic tx_busy;
  logic rx_req_s1_q;
  logic rx_req_s2_q;
  logic rx_ack_q;
  logic rx_pend;
  csdr_quad_t gain_w;

  // Link domain state, declared early for the crossings
  logic lrst_s1_q;
  logic lrst_n;
  csdr_cfg_t cfg_s1_q;
  csdr_cfg_t cfg_q;
  logic fs_q;
  logic [8:0] cnt_q;
  logic [8:0] last;
  logic [8:0] pos;
  logic [8:0] npos;
  logic frame_edge;
  logic is_tdm;
  logic [23:0] sh1_q;
  logic [23:0] sh2_q;
  logic [23:0] new1;
  logic [23:0] new2;
  logic [CHAIN_LEN-1:0] chain_q;
  csdr_quad_t rx_q;
  csdr_quad_t rx_hold_q;
  logic rx_req_q;
  logic rx_ack_s1_q;
  logic rx_ack_s2_q;
  csdr_quad_t tx_word_q;
  logic tx_ack_q;
  logic tx_req_s1_q;
  logic tx_req_s2_q;
  logic [4:0] nbit;
  logic [4:0] nidx;
  logic [3:0] nslot;

  always_comb
  begin
    logic signed [CSDR_RAW_W-1:0] diff;
    diff = '0;
    for (int i = 0; i < CSDR_NUM_CH; i++)
    begin
      over_w[i] = ($signed(conv_raw[i]) > CSDR_RAW_POS) || ($signed(conv_raw[i]) < CSDR_RAW_NEG);
      sat_w[i] = csdr_sat(conv_raw[i]);
      diff = $signed({{2{sat_w[i][23]}}, sat_w[i]})
        - $signed({{2{dc_q[i][HPF_K+23]}}, dc_q[i][HPF_K+23:HPF_K]});
      hpf_w[i] = highpass_enable ? csdr_sat(diff) : sat_w[i];
    end
  end

  assign tx_busy = tx_req_q != tx_ack_s2_q;

  // Samples arrive once per decimated modulator frame
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      dc_q <= '0;
    else if (conv_valid && highpass_enable)
      for (int i = 0; i < CSDR_NUM_CH; i++)
        dc_q[i] <= dc_q[i] + {{HPF_K{hpf_w[i][23]}}, hpf_w[i]};
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tx_hold_q <= '0;
      tx_req_q <= 1'b0;
    end
    else if (conv_valid && !tx_busy)
    begin
      tx_hold_q <= hpf_w;
      tx_req_q <= ~tx_req_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      input_overflow <= 1'b0;
    else if (conv_valid && |over_w)
      input_overflow <= 1'b1;
    else if (overflow_clear)
      input_overflow <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tx_ack_s1_q <= 1'b0;
      tx_ack_s2_q <= 1'b0;
      rx_req_s1_q <= 1'b0;
      rx_req_s2_q <= 1'b0;
    end
    else
    begin
      tx_ack_s1_q <= tx_ack_q;
      tx_ack_s2_q <= tx_ack_s1_q;
      rx_req_s1_q <= rx_req_q;
      rx_req_s2_q <= rx_req_s1_q;
    end
  end

  assign rx_pend = rx_req_s2_q != rx_ack_q;

  // Coarse gain: one arithmetic shift per 16 attenuation steps
  always_comb
  begin
    logic [8:0] sum;
    sum = '0;
    for (int i = 0; i < CSDR_NUM_CH; i++)
    begin
      sum = {1'b0, chan_att[i]} + {1'b0, master_att};
      if (mute[i] || sum > CSDR_ATT_MAX)
        gain_w[i] = '0;
      else
        gain_w[i] = $signed(rx_hold_q[i]) >>> sum[7:CSDR_ATT_STEP_SHIFT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rx_ack_q <= 1'b0;
      playback_channels <= '0;
      playback_valid <= 1'b0;
    end
    else
    begin
      playback_valid <= rx_pend;
      if (rx_pend)
      begin
        rx_ack_q <= rx_req_s2_q;
        playback_channels <= gain_w;
      end
    end
  end

  // Link domain
  always_ff @(posedge bit_clk)
  begin
    lrst_s1_q <= reset_n;
    lrst_n <= lrst_s1_q;
    cfg_s1_q <= serial_port_control;
    cfg_q <= cfg_s1_q;
  end

  assign is_tdm = cfg_q.fmt == CSDR_FMT_TDM;
  assign last = is_tdm ? (cfg_q.tdm16 ? CSDR_LAST_TDM16 : CSDR_LAST_TDM8) : CSDR_LAST_PCM;
  // I2S frames open on the falling sync edge, others on the rising one
  assign frame_edge = (cfg_q.fmt == CSDR_FMT_I2S) ? (fs_q && !frame_sync)
    : (!fs_q && frame_sync);
  assign npos = (cnt_q >= last) ? '0 : cnt_q + 9'h001;
  assign pos = frame_edge ? ((cfg_q.fmt == CSDR_FMT_I2S) ? last : '0) : npos;
  assign new1 = {sh1_q[22:0], serial_in_primary};
  assign new2 = {sh2_q[22:0], serial_in_secondary};

  always_ff @(posedge bit_clk)
  begin
    if (!lrst_n)
    begin
      fs_q <= 1'b0;
      cnt_q <= '0;
      sh1_q <= '0;
      sh2_q <= '0;
      chain_q <= '0;
    end
    else
    begin
      fs_q <= frame_sync;
      cnt_q <= pos;
      chain_q <= {chain_q[CHAIN_LEN-2:0], serial_in_secondary};
      if (pos[4:0] < CSDR_IN_BITS)
      begin
        sh1_q <= new1;
        sh2_q <= new2;
      end
    end
  end

  always_ff @(posedge bit_clk)
  begin
    if (!lrst_n)
      rx_q <= '0;
    else if (pos[4:0] == CSDR_MSB_IDX)
    begin
      if (!is_tdm)
      begin
        rx_q[pos[5]] <= new1;
        rx_q[2 + pos[5]] <= new2;
      end
      else if (pos[8:7] == cfg_q.playback_slot_group_select[1:0])
        rx_q[pos[6:5]] <= cfg_q.playback_slot_group_select[2] ? new2 : new1;
    end
  end

  always_ff @(posedge bit_clk)
  begin
    if (!lrst_n)
    begin
      rx_hold_q <= '0;
      rx_req_q <= 1'b0;
      rx_ack_s1_q <= 1'b0;
      rx_ack_s2_q <= 1'b0;
      tx_word_q <= '0;
      tx_ack_q <= 1'b0;
      tx_req_s1_q <= 1'b0;
      tx_req_s2_q <= 1'b0;
    end
    else
    begin
      rx_ack_s1_q <= rx_ack_q;
      rx_ack_s2_q <= rx_ack_s1_q;
      tx_req_s1_q <= tx_req_q;
      tx_req_s2_q <= tx_req_s1_q;
      if (pos == last && rx_req_q == rx_ack_s2_q)
      begin
        rx_hold_q <= rx_q;
        rx_req_q <= ~rx_req_q;
      end
      if (pos == last && tx_req_s2_q != tx_ack_q)
      begin
        tx_word_q <= tx_hold_q;
        tx_ack_q <= tx_req_s2_q;
      end
    end
  end

  assign nslot = npos[8:5];
  assign nbit = npos[4:0];
  assign nidx = CSDR_MSB_IDX - nbit;

  // Launch the bit for the next rising edge
  always_ff @(negedge bit_clk)
  begin
    if (!lrst_n)
    begin
      serial_out_primary <= 1'b0;
      serial_out_secondary <= 1'b0;
    end
    else if (is_tdm)
    begin
      serial_out_secondary <= 1'b0;
      if (nslot >= 4'(CSDR_NUM_CH))
        serial_out_primary <= cfg_q.output_chain_enable && chain_q[CHAIN_LEN-1];
      else
        serial_out_primary <= (nbit < CSDR_IN_BITS) && tx_word_q[nslot[1:0]][nidx];
    end
    else
    begin
      serial_out_primary <= (nbit < csdr_word_bits(cfg_q.out_width))
        && tx_word_q[nslot[0]][nidx];
      serial_out_secondary <= (nbit < csdr_word_bits(cfg_q.out_width))
        && tx_word_q[2 + nslot[0]][nidx];
    end
  end

  chk_ovf_set: assert property (@(posedge clk) disable iff (!reset_n)
    conv_valid && |over_w |=> input_overflow)
    else $error("overflow flag not set");

  chk_sat_clamp: assert property (@(posedge clk) disable iff (!reset_n)
    conv_valid && !tx_busy && !highpass_enable && $signed(conv_raw[1]) > CSDR_RAW_POS
    |=> tx_hold_q[1] == CSDR_SAT_POS)
    else $error("positive clamp wrong");

  chk_hpf_bypass: assert property (@(posedge clk) disable iff (!reset_n)
    conv_valid && !tx_busy && !highpass_enable |=> tx_hold_q == $past(sat_w))
    else $error("bypass altered samples");

  chk_mute_zero: assert property (@(posedge clk) disable iff (!reset_n)
    rx_pend && mute[1] |=> playback_valid && playback_channels[1] == '0)
    else $error("muted channel not silent");

  chk_att_sum: assert property (@(posedge clk) disable iff (!reset_n)
    rx_pend && ({1'b0, chan_att[2]} + {1'b0, master_att}) > CSDR_ATT_MAX
    |=> playback_channels[2] == '0)
    else $error("summed attenuation not muting");

  chk_tdm_pad: assert property (@(posedge bit_clk) disable iff (!lrst_n)
    is_tdm && nslot < 4'(CSDR_NUM_CH) && nbit >= CSDR_IN_BITS |-> !serial_out_primary)
    else $error("slot padding not zero");

  chk_chain_off: assert property (@(posedge bit_clk) disable iff (!lrst_n)
    is_tdm && !cfg_q.output_chain_enable && nslot >= 4'(CSDR_NUM_CH) |-> !serial_out_primary)
    else $error("chain slots not zero");

  chk_chain_fwd: assert property (@(posedge bit_clk) disable iff (!lrst_n)
    is_tdm && cfg_q.output_chain_enable && nslot >= 4'(CSDR_NUM_CH)
    |-> serial_out_primary == chain_q[CHAIN_LEN-1])
    else $error("chain data not forwarded");

  chk_sec_idle: assert property (@(posedge bit_clk) disable iff (!lrst_n)
    is_tdm |-> !serial_out_secondary)
    else $error("secondary active in TDM");

  sequence lj_edge_s;
    cfg_q.fmt == CSDR_FMT_LJ && !fs_q && frame_sync;
  endsequence

  sequence i2s_edge_s;
    cfg_q.fmt == CSDR_FMT_I2S && fs_q && !frame_sync;
  endsequence

  chk_lj_align: assert property (@(posedge bit_clk) disable iff (!lrst_n)
    lj_edge_s |=> cnt_q == '0 ##1 cnt_q == 9'h001)
    else $error("left justified alignment wrong");

  chk_i2s_align: assert property (@(posedge bit_clk) disable iff (!lrst_n)
    i2s_edge_s |=> cnt_q == CSDR_LAST_PCM ##1 cnt_q == '0)
    else $error("I2S alignment wrong");

endmodule

// ===== verilog/csdr_pkg.sv
package csdr_pkg;
  localparam int CSDR_NUM_CH = 4;
  localparam int CSDR_SAMPLE_W = 24;
  localparam int CSDR_SLOT_W = 32;
  localparam int CSDR_RAW_W = 26;
  localparam int CSDR_CHAIN_LEN = CSDR_NUM_CH * CSDR_SLOT_W;
  localparam int CSDR_HPF_K = 10;
  localparam int CSDR_MOD_RATE_KHZ = 6144;
  localparam int CSDR_MCLK_INT_KHZ = 12288;
  localparam logic [23:0] CSDR_SAT_POS = 24'h7FFFFF;
  localparam logic [23:0] CSDR_SAT_NEG = 24'h800000;
  localparam logic signed [CSDR_RAW_W-1:0] CSDR_RAW_POS = 26'sh07FFFFF;
  localparam logic signed [CSDR_RAW_W-1:0] CSDR_RAW_NEG = 26'sh3800000;
  localparam logic [8:0] CSDR_LAST_TDM16 = 9'h1FF;
  localparam logic [8:0] CSDR_LAST_TDM8 = 9'h0FF;
  localparam logic [8:0] CSDR_LAST_PCM = 9'h03F;
  localparam logic [4:0] CSDR_MSB_IDX = 5'h17;
  localparam logic [4:0] CSDR_IN_BITS = 5'h18;
  localparam logic [8:0] CSDR_ATT_MAX = 9'h0FF;
  localparam int CSDR_ATT_STEP_SHIFT = 4;

  typedef enum logic [1:0] {CSDR_FMT_LJ, CSDR_FMT_I2S, CSDR_FMT_TDM} csdr_fmt_t;

  typedef struct packed {
    csdr_fmt_t fmt;
    logic output_chain_enable;
    logic tdm16;
    logic [1:0] out_width;
    logic [2:0] playback_slot_group_select;
  } csdr_cfg_t;

  typedef logic [CSDR_NUM_CH-1:0][CSDR_SAMPLE_W-1:0] csdr_quad_t;

  function automatic logic [4:0] csdr_word_bits(input logic [1:0] code);
    case (code)
      2'h0: csdr_word_bits = 5'h10;
      2'h1: csdr_word_bits = 5'h12;
      2'h2: csdr_word_bits = 5'h14;
      default: csdr_word_bits = 5'h18;
    endcase
  endfunction

  function automatic logic [23:0] csdr_sat(input logic signed [CSDR_RAW_W-1:0] x);
    if (x > CSDR_RAW_POS)
      csdr_sat = CSDR_SAT_POS;
    else if (x < CSDR_RAW_NEG)
      csdr_sat = CSDR_SAT_NEG;
    else
      csdr_sat = x[23:0];
  endfunction
endpackage

// ===== testbench/csdr_host_model.sv
`timescale 1ns/100ps
module csdr_host_model (
  input wire logic run,
  input wire logic i2s,
  input wire logic [9:0] frame_bits,
  input wire logic [511:0] tx_pri,
  input wire logic [511:0] tx_sec,
  input wire logic serial_out_primary,
  input wire logic serial_out_secondary,
  output logic bit_clk = 1'b0,
  output logic frame_sync = 1'b0,
  output logic sd_pri = 1'b0,
  output logic sd_sec = 1'b0,
  output logic [511:0] rx_pri,
  output logic [511:0] rx_sec,
  output int frames = 0
);
  logic [9:0] nxt = 10'h000;
  logic [9:0] idx = 10'h000;
  logic live = 1'b0;
  logic [511:0] acc_pri;
  logic [511:0] acc_sec;
  wire logic [9:0] pos = (nxt == 10'h000 && i2s) ? frame_bits - 10'h001 : nxt - {9'h000, i2s};

  always #6 bit_clk = ~bit_clk;

  // Regular frames; sync and data launched on the falling edge
  always @(negedge bit_clk)
  begin
    live <= run;
    if (!run)
    begin
      nxt <= 10'h000;
      frame_sync <= i2s;
      sd_pri <= ~sd_pri;
      sd_sec <= ~sd_sec;
    end
    else
    begin
      idx <= pos;
      sd_pri <= tx_pri[pos];
      sd_sec <= tx_sec[pos];
      frame_sync <= (nxt < (frame_bits >> 1)) ^ i2s;
      nxt <= (nxt == frame_bits - 10'h001) ? 10'h000 : nxt + 10'h001;
    end
  end

  // Capture on the rising edge, snapshot per frame
  always @(posedge bit_clk)
  if (live)
  begin
    acc_pri[idx] = serial_out_primary;
    acc_sec[idx] = serial_out_secondary;
    if (idx == frame_bits - 10'h001)
    begin
      rx_pri <= acc_pri;
      rx_sec <= acc_sec;
      frames <= frames + 1;
    end
  end
endmodule

// ===== testbench/tb.sv
`timescale 1ns/100ps
module tb;
  import csdr_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic bit_clk;
  logic frame_sync;
  logic sd_pri;
  logic sd_sec;
  logic out_pri;
  logic out_sec;
  csdr_cfg_t cfg = '0;
  logic conv_valid = 1'b0;
  logic conv_on = 1'b1;
  logic [3:0][25:0] conv_raw = {26'h37FFFFF, 26'h3FFFFFF, 26'h0800000, 26'h0123456};
  logic overflow_clear = 1'b0;
  logic hpf = 1'b0;
  logic pv;
  logic input_overflow;
  logic [3:0] mute = 4'h0;
  logic [3:0][7:0] chan_att = '0;
  logic [7:0] master_att = 8'h00;
  csdr_quad_t play;
  logic run = 1'b0;
  logic i2s = 1'b0;
  logic [9:0] fb = 10'h040;
  logic [511:0] tx_pri;
  logic [511:0] tx_sec;
  logic [511:0] rx_pri;
  logic [511:0] rx_sec;
  int nframes;
  int tick = 0;
  int miscompares = 0;
  int num_checks = 0;
  logic [23:0] sat_exp [4] = '{24'h123456, 24'h7FFFFF, 24'hFFFFFF, 24'h800000};

  csdr_routing dut (.clk(clk), .reset_n(reset_n), .bit_clk(bit_clk), .frame_sync(frame_sync),
    .serial_in_primary(sd_pri), .serial_in_secondary(sd_sec), .serial_out_primary(out_pri),
    .serial_out_secondary(out_sec), .serial_port_control(cfg), .highpass_enable(hpf),
    .conv_valid(conv_valid), .conv_raw(conv_raw), .overflow_clear(overflow_clear),
    .input_overflow(input_overflow), .mute(mute), .chan_att(chan_att), .master_att(master_att),
    .playback_channels(play), .playback_valid(pv));

  csdr_host_model host (.run(run), .i2s(i2s), .frame_bits(fb), .tx_pri(tx_pri), .tx_sec(tx_sec),
    .serial_out_primary(out_pri), .serial_out_secondary(out_sec), .bit_clk(bit_clk),
    .frame_sync(frame_sync), .sd_pri(sd_pri), .sd_sec(sd_sec), .rx_pri(rx_pri),
    .rx_sec(rx_sec), .frames(nframes));

  always #50 clk = ~clk;

  // Converter sets offered often; busy ones are dropped
  always @(negedge clk)
  begin
    tick <= tick + 1;
    conv_valid <= conv_on && (tick % 40 == 0);
  end

  function automatic logic [31:0] val(input int line, input int s);
    return (line != 0 ? 32'h990022FF : 32'h110022FF) | (32'(s) << 16);
  endfunction

  function automatic logic [31:0] slot(input logic [511:0] v, input int s);
    return {<<{v[32*s+:32]}};
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wait_frames(input int n);
    int f0;
    f0 = nframes;
    for (int i = 0; i < 5000 && nframes < f0 + n; i++)
      @(negedge clk);
    if (nframes < f0 + n)
      miscompares++;
  endtask

  // Playback strobe must pulse for exactly one cycle
  task wait_valid;
    int n;
    n = 0;
    while (pv !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk(32'(pv), 32'h1);
    @(negedge clk);
    chk(32'(pv), 32'h0);
  endtask

  task start(input csdr_fmt_t f, input logic t16, input logic ch, input logic [1:0] w);
    @(negedge clk);
    reset_n = 1'b0;
    run = 1'b0;
    cfg = '{f, ch, t16, w, 3'h0};
    i2s = (f == CSDR_FMT_I2S);
    fb = f != CSDR_FMT_TDM ? 10'h040 : t16 ? 10'h200 : 10'h100;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    run = 1'b1;
    // Let a converter set reach the output words first
    repeat (100) @(negedge clk);
    wait_frames(3);
  endtask

  task sc_hpf;
    start(CSDR_FMT_TDM, 1'b1, 1'b0, 2'h0);
    hpf = 1'b1;
    wait_frames(5);
    chk(slot(rx_pri, 2), 32'h0);
    chk(32'(slot(rx_pri, 0) < {sat_exp[0], 8'h00}), 32'h1);
    hpf = 1'b0;
  endtask

  task sc_tdm_out(input logic t16, input logic ch);
    start(CSDR_FMT_TDM, t16, ch, 2'h0);
    for (int s = 0; s < 4; s++)
      chk(slot(rx_pri, s), {sat_exp[s], 8'h00});
    for (int s = 4; s < (t16 ? 16 : 8); s++)
      chk(slot(rx_pri, s), ch ? val(1, s - 4) : 32'h0);
    chk(32'(input_overflow), 32'h1);
    conv_on = 1'b0;
    wait_frames(2);
    overflow_clear = 1'b1;
    @(negedge clk);
    overflow_clear = 1'b0;
    @(negedge clk);
    chk(32'(input_overflow), 32'h0);
    conv_on = 1'b1;
  endtask

  task sc_group;
    start(CSDR_FMT_TDM, 1'b1, 1'b0, 2'h0);
    for (int g = 0; g < 8; g++)
    begin
      cfg.playback_slot_group_select = 3'(g);
      wait_frames(3);
      for (int i = 0; i < 4; i++)
        chk(32'(play[i]), val(g / 4, 4 * (g % 4) + i) >> 8);
    end
  endtask

  task sc_volume;
    logic [23:0] e;
    mute = 4'h2;
    chan_att = {8'h00, 8'hF0, 8'h00, 8'h20};
    master_att = 8'h10;
    wait_frames(3);
    for (int i = 0; i < 4; i++)
    begin
      e = 24'(val(1, 12 + i) >> 8);
      chk(32'(play[i]), (i == 1 || i == 2) ? 32'h0 : {8'h00, 24'($signed(e) >>> (i == 0 ? 3 : 1))});
    end
    mute = 4'h0;
    chan_att = '0;
    master_att = 8'h00;
  endtask

  task sc_pcm(input csdr_fmt_t f, input logic [1:0] w);
    logic [31:0] mask;
    start(f, 1'b0, 1'b0, w);
    mask = ~(32'hFFFFFFFF >> (16 + 2 * w + (w == 2'h3 ? 2 : 0)));
    for (int i = 0; i < 4; i++)
    begin
      chk(slot(i < 2 ? rx_pri : rx_sec, i % 2), {sat_exp[i], 8'h00} & mask);
      chk(32'(play[i]), val(i / 2, i % 2) >> 8);
    end
    wait_valid;
  endtask

  task final_report;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    for (int s = 0; s < 16; s++)
    begin
      tx_pri[32*s+:32] = {<<{val(0, s)}};
      tx_sec[32*s+:32] = {<<{val(1, s)}};
    end
    sc_tdm_out(1'b1, 1'b0);
    sc_tdm_out(1'b1, 1'b1);
    sc_tdm_out(1'b0, 1'b1);
    sc_hpf;
    sc_group;
    sc_volume;
    sc_pcm(CSDR_FMT_LJ, 2'h0);
    sc_pcm(CSDR_FMT_I2S, 2'h1);
    sc_pcm(CSDR_FMT_LJ, 2'h2);
    sc_pcm(CSDR_FMT_I2S, 2'h3);
    final_report;
  end

  initial
  begin
    #2000000;
    miscompares++;
    final_report;
  end
endmodule
